// >>> rtl/rls_pkg.sv
// Package for the reset and low-power sequencer.
// Assumes a single 50 MHz clock domain and a plain register port.
package rls_pkg;
    // Register offsets and reset values.
    localparam logic [7:0] DATA_WINDOW_SELECT_OFS = 8'hC9;
    localparam logic [7:0] PROGRAM_PAGE_SELECT_OFS = 8'hCA;
    localparam logic [7:0] RAM_BANK_SELECT_OFS = 8'hCB;
    localparam logic [7:0] WATCHDOG_COUNT_OFS = 8'hD8;
    localparam logic [7:0] CONTROL_OFS = 8'hE0;
    localparam logic [7:0] STATUS_OFS = 8'hE1;
    localparam logic [7:0] WATCHDOG_COUNT_RST = 8'hFE;
    localparam logic [7:0] PRESCALER_RST = 8'h7F;
    localparam logic [7:0] TIMER_COUNT_RST = 8'hFF;
    localparam logic [11:0] RESET_VECTOR_LO = 12'hFFE;
    localparam logic [11:0] RESET_VECTOR_HI = 12'hFFF;
    // Control register field positions.
    localparam int CTL_WDG_EN_BIT = 0;
    localparam int CTL_TMR_IE_BIT = 1;
    localparam int CTL_ADC_IE_BIT = 2;
    localparam int CTL_EXT_IE_BIT = 3;
    // Timing: stabilisation delay in oscillator cycles.
    localparam int STAB_CYCLES = 2048;
    localparam int CNT_W = 12;
    // Sequencer states.
    typedef enum logic [2:0] {
        RLS_RESET = 3'b000,
        RLS_STAB = 3'b001,
        RLS_VEC_LO = 3'b010,
        RLS_VEC_HI = 3'b011,
        RLS_RUN = 3'b100,
        RLS_WAIT = 3'b101,
        RLS_STOP = 3'b110
    } rls_state_t;
    // Register access request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rls_bus_t;
    // Wake sources from the core and peripherals.
    typedef struct packed {
        logic tmr_irq;
        logic adc_irq;
        logic ext_irq;
    } rls_irq_t;
endpackage

// >>> rtl/rls_sequencer.sv
// Reset and low-power sequencer: reset pin, power-on, watchdog, WAIT/STOP.
// Assumes mclk is the oscillator, rst is the power-on detector pulse, and
// the reset pin is driven open-drain by this block with a pull-up.
//
// Contract
// (R01) During reset, I/O are pulled-up inputs and no instruction runs.
// (R02) Power-on waits oscillator stabilisation before first fetch.
// (R03) Count 2048 cycles after pin high before releasing reset.
// (R04) Stay in reset while pin low; release starts only when high.
// (R05) Power-on pulse alone starts the reset procedure.
// (R06) External circuit holds pin low on slow supply ramps.
// (R07) Watchdog end of count pulls pin low; reset when pin reads low.
// (R08) Watchdog reset clears watchdog, releasing pull-down and pin rises.
// (R09) Reset clears stack and loads PC from vector at FFE/FFF.
// (R10) Start masked in non-maskable mode; return instruction unmasks.
// (R11) On that return, pending interrupt is serviced first.
// (R12) Reset keeps window, page and bank selects; clears others.
// (R13) Reset sets timer prescaler to 7F and count to FF.
// (R14) Reset presets watchdog count at D8 to FE.
// (R15) WAIT halts execution, keeps state, clock keeps running.
// (R16) Enabled timer or converter interrupt ends WAIT.
// (R17) Interrupt leaves WAIT with no stabilisation delay.
// (R18) STOP is available only with watchdog disabled.
// (R19) STOP gates the oscillator and waits for interrupt or reset.
// (R20) Interrupt leaving STOP waits full stabilisation first.
// (R21) Reset in WAIT or STOP runs the full reset procedure.
// (R22) From main program, any interrupt wakes; handler then resume. Any interrupt ends WAIT here, but only ext_irq ends STOP.
// (R23) STOP with watchdog active acts as WAIT.
// (R24) WAIT or STOP is refused while an enabled interrupt pends.
// (R25) STOP exit delay reuses the 2048-cycle reset counter.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module rls_sequencer #(
    parameter int STAB_COUNT = rls_pkg::STAB_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire rls_pkg::rls_bus_t bus,
    output logic [7:0] rdata,
    input wire rls_pkg::rls_irq_t irq,
    input wire logic wait_req,
    input wire logic stop_req,
    input wire logic return_from_handler_instruction,
    input wire logic wdg_tick,
    input wire logic wdg_refresh,
    input wire logic [7:0] rom_data,
    output logic [11:0] rom_addr,
    output logic core_run,
    output logic io_reset,
    output logic osc_enable,
    output logic nmi_mode,
    output logic service_pending,
    output logic stack_clear,
    output logic [11:0] pc_load,
    output logic pc_load_en,
    output logic [7:0] timer_prescaler,
    output logic [7:0] timer_count_register
);
    import rls_pkg::*;

    rls_state_t state_reg;
    rls_state_t state_next;
    logic [2:0] pin_sync_reg;
    logic pin_level_reg;
    logic [CNT_W-1:0] stab_cnt_reg;
    logic [7:0] data_window_select_reg;
    logic [7:0] program_page_select_reg;
    logic [7:0] ram_bank_select_reg;
    logic [7:0] watchdog_count_reg;
    logic [3:0] control_reg;
    logic wdg_pull_reg;
    logic [7:0] vec_lo_reg;
    logic stab_done;
    logic irq_enabled;
    logic any_irq;
    logic wdg_on;

    localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_COUNT - 1);

    // Reset pin passes three flops; level changes when the last two agree.
    // The pin is asynchronous, so the first flop may go metastable; only
    // the second and third stages are ever compared or used.
    always_ff @(posedge mclk) begin
        pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_in};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_level_reg <= 1'b0;
        end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_level_reg <= pin_sync_reg[2];
        end
    end

    assign wdg_on = control_reg[CTL_WDG_EN_BIT];
    assign irq_enabled = (irq.tmr_irq & control_reg[CTL_TMR_IE_BIT])
        | (irq.adc_irq & control_reg[CTL_ADC_IE_BIT])
        | (irq.ext_irq & control_reg[CTL_EXT_IE_BIT]);
    assign any_irq = irq.tmr_irq | irq.adc_irq | irq.ext_irq;
    assign stab_done = (stab_cnt_reg == STAB_LAST);

    // Next state of the sequencer.
    // A low pin overrides every state except stabilisation, which already
    // falls back to reset by itself, so no sleep state can mask a reset.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RLS_RESET: begin
                if (pin_level_reg) begin
                    state_next = RLS_STAB; // [R04]
                end
            end
            RLS_STAB: begin
                if (!pin_level_reg) begin
                    state_next = RLS_RESET; // [R04]
                end else if (stab_done) begin
                    state_next = RLS_VEC_LO; // [R02] [R03] [R25]
                end
            end
            RLS_VEC_LO: state_next = RLS_VEC_HI; // [R09]
            RLS_VEC_HI: state_next = RLS_RUN; // [R09]
            RLS_RUN: begin
                if (irq_enabled) begin
                    state_next = RLS_RUN; // [R24]
                end else if (stop_req && !wdg_on) begin
                    state_next = RLS_STOP; // [R18]
                end else if (stop_req || wait_req) begin
                    state_next = RLS_WAIT; // [R15] [R23]
                end
            end
            RLS_WAIT: begin
                if (irq_enabled || any_irq) begin
                    state_next = RLS_RUN; // [R16] [R17] [R22]
                end
            end
            RLS_STOP: begin
                if (irq.ext_irq) begin
                    state_next = RLS_STAB; // [R19] [R20]
                end
            end
            default: state_next = RLS_RESET;
        endcase
        if (!pin_level_reg && state_reg != RLS_STAB) begin
            state_next = RLS_RESET; // [R07] [R21]
        end
    end

    // State register; the power-on pulse forces reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= RLS_RESET; // [R05]
        end else begin
            state_reg <= state_next;
        end
    end

    // Stabilisation counter runs only in the stabilisation state.
    // It restarts from zero on every entry, after reset and after STOP.
    always_ff @(posedge mclk) begin
        if (rst || state_reg != RLS_STAB) begin
            stab_cnt_reg <= '0;
        end else if (!stab_done) begin
            stab_cnt_reg <= stab_cnt_reg + 1'b1; // [R03] [R25]
        end
    end

    // Watchdog pull-down: set at end of count, cleared by reset entry.
    always_ff @(posedge mclk) begin
        if (rst || state_reg == RLS_RESET) begin
            wdg_pull_reg <= 1'b0; // [R08]
        end else if (wdg_on && wdg_tick && !wdg_refresh
                     && watchdog_count_reg == 8'h00) begin
            wdg_pull_reg <= 1'b1; // [R07]
        end
    end

    // Watchdog count, preset on reset and reloaded by software.
    always_ff @(posedge mclk) begin
        if (rst || state_reg == RLS_RESET) begin
            watchdog_count_reg <= WATCHDOG_COUNT_RST; // [R14]
        end else if (bus.wr && bus.addr == WATCHDOG_COUNT_OFS) begin
            watchdog_count_reg <= bus.wdata;
        end else if (wdg_on && wdg_tick && watchdog_count_reg != 8'h00) begin
            watchdog_count_reg <= watchdog_count_reg - 1'b1;
        end
    end

    // Control register cleared on reset.
    always_ff @(posedge mclk) begin
        if (rst || state_reg == RLS_RESET) begin
            control_reg <= '0; // [R12]
        end else if (bus.wr && bus.addr == CONTROL_OFS) begin
            control_reg <= bus.wdata[3:0];
        end
    end

    // Selection registers keep contents across reset.
    always_ff @(posedge mclk) begin
        if (bus.wr && bus.addr == DATA_WINDOW_SELECT_OFS) begin
            data_window_select_reg <= bus.wdata; // [R12]
        end
        if (bus.wr && bus.addr == PROGRAM_PAGE_SELECT_OFS) begin
            program_page_select_reg <= bus.wdata;
        end
        if (bus.wr && bus.addr == RAM_BANK_SELECT_OFS) begin
            ram_bank_select_reg <= bus.wdata;
        end
    end

    // Timer reset values.
    always_ff @(posedge mclk) begin
        if (rst || state_reg == RLS_RESET) begin
            timer_prescaler <= PRESCALER_RST; // [R13]
            timer_count_register <= TIMER_COUNT_RST;
        end
    end

    // Read data, one cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                DATA_WINDOW_SELECT_OFS: rdata <= data_window_select_reg;
                PROGRAM_PAGE_SELECT_OFS: rdata <= program_page_select_reg;
                RAM_BANK_SELECT_OFS: rdata <= ram_bank_select_reg;
                WATCHDOG_COUNT_OFS: rdata <= watchdog_count_reg;
                CONTROL_OFS: rdata <= {4'h0, control_reg};
                STATUS_OFS: rdata <= {5'h00, state_reg};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Vector fetch and program-counter load.
    always_ff @(posedge mclk) begin
        if (rst) begin
            vec_lo_reg <= 8'h00;
            pc_load <= 12'h000;
            pc_load_en <= 1'b0;
        end else begin
            pc_load_en <= 1'b0;
            if (state_reg == RLS_VEC_LO) begin
                vec_lo_reg <= rom_data; // [R09]
            end
            if (state_reg == RLS_VEC_HI) begin
                pc_load <= {rom_data[3:0], vec_lo_reg}; // [R09]
                pc_load_en <= 1'b1;
            end
        end
    end

    // Non-maskable mode from reset until the return instruction.
    always_ff @(posedge mclk) begin
        if (rst || state_reg == RLS_RESET) begin
            nmi_mode <= 1'b1; // [R10]
            service_pending <= 1'b0;
        end else begin
            service_pending <= 1'b0;
            if (nmi_mode && return_from_handler_instruction
                && state_reg == RLS_RUN) begin
                nmi_mode <= 1'b0; // [R10]
                service_pending <= irq_enabled; // [R11]
            end
        end
    end

    assign rom_addr = (state_reg == RLS_VEC_HI) ? RESET_VECTOR_HI
                                                 : RESET_VECTOR_LO;
    assign stack_clear = (state_reg == RLS_RESET); // [R09]
    assign io_reset = (state_reg == RLS_RESET) || (state_reg == RLS_STAB)
                      || (state_reg == RLS_VEC_LO)
                      || (state_reg == RLS_VEC_HI); // [R01]
    assign core_run = (state_reg == RLS_RUN); // [R01] [R15]
    assign osc_enable = (state_reg != RLS_STOP); // [R19]
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = wdg_pull_reg; // [R07]

    // Checks below watch only what this block drives; all of them are
    // quiet while the power-on pulse is high.

    // Sleep entry: STOP only with the watchdog off, never over a request.
    a_stop_gate: assert property (@(posedge mclk) // [R18]
        disable iff (rst)
        (state_reg == RLS_RUN && state_next == RLS_STOP) |-> !wdg_on)
        else $error("STOP entered with watchdog on.");
    a_no_sleep_pend: assert property (@(posedge mclk) // [R24]
        disable iff (rst)
        (state_reg == RLS_RUN && irq_enabled && pin_level_reg)
        |=> state_reg == RLS_RUN)
        else $error("Sleep entered with pending interrupt.");
    a_stop_as_wait: assert property (@(posedge mclk) // [R23]
        disable iff (rst)
        (state_reg == RLS_RUN && !irq_enabled && stop_req && wdg_on
         && pin_level_reg) |=> state_reg == RLS_WAIT)
        else $error("STOP with watchdog on did not become WAIT.");

    // Pin reset, I/O hold and the release delay.
    a_pin_low_reset: assert property (@(posedge mclk) // [R04]
        disable iff (rst)
        (!pin_level_reg && state_reg == RLS_RUN) |=> state_reg == RLS_RESET)
        else $error("Pin low did not reset.");
    a_stab_length: assert property (@(posedge mclk) // [R03]
        disable iff (rst)
        (state_reg == RLS_VEC_LO) |-> $past(stab_cnt_reg) == STAB_LAST)
        else $error("Release before stabilisation count.");
    a_stab_hold: assert property (@(posedge mclk) // [R03]
        disable iff (rst)
        (state_reg == RLS_STAB && pin_level_reg && !stab_done)
        |=> state_reg == RLS_STAB)
        else $error("Stabilisation left early.");
    a_io_hold: assert property (@(posedge mclk) // [R01]
        disable iff (rst)
        (state_reg == RLS_RESET) |-> (io_reset && !core_run && stack_clear))
        else $error("Reset state did not hold the I/O and core.");

    // Reset fetch: low vector byte, then high byte, then the load strobe.
    sequence s_fetch_lo;
        state_reg == RLS_VEC_LO && rom_addr == RESET_VECTOR_LO
        && pin_level_reg;
    endsequence
    sequence s_fetch_hi;
        state_reg == RLS_VEC_HI && rom_addr == RESET_VECTOR_HI;
    endsequence
    a_vector_fetch: assert property (@(posedge mclk) // [R09]
        disable iff (rst)
        s_fetch_lo |=> s_fetch_hi ##1 pc_load_en)
        else $error("Reset vector fetch out of order.");

    // Register presets on reset entry and the mode change on return.
    a_wdg_preset: assert property (@(posedge mclk) // [R14]
        disable iff (rst)
        (state_reg == RLS_RESET)
        |=> watchdog_count_reg == WATCHDOG_COUNT_RST)
        else $error("Watchdog count not preset.");
    a_timer_preset: assert property (@(posedge mclk) // [R13]
        disable iff (rst)
        (state_reg == RLS_RESET) |=> (timer_prescaler == PRESCALER_RST
        && timer_count_register == TIMER_COUNT_RST))
        else $error("Timer values not preset.");
    a_nmi_clear: assert property (@(posedge mclk) // [R10] [R11]
        disable iff (rst)
        (nmi_mode && return_from_handler_instruction && state_reg == RLS_RUN)
        |=> (!nmi_mode && service_pending == $past(irq_enabled)))
        else $error("Return did not leave non-maskable mode.");

    // Watchdog pull-down set at end of count and dropped on reset entry.
    a_wdg_pull_set: assert property (@(posedge mclk) // [R07]
        disable iff (rst)
        (wdg_on && wdg_tick && !wdg_refresh && watchdog_count_reg == 8'h00
         && state_reg != RLS_RESET) |=> reset_pin_oe)
        else $error("Watchdog end of count did not pull the pin.");
    a_pull_release: assert property (@(posedge mclk) // [R08]
        disable iff (rst)
        (state_reg == RLS_RESET) |=> !reset_pin_oe)
        else $error("Pull-down not released.");

    // Sleep states, their exits and the oscillator gate.
    a_wait_fast: assert property (@(posedge mclk) // [R16]
        disable iff (rst)
        (state_reg == RLS_WAIT && irq.tmr_irq && control_reg[CTL_TMR_IE_BIT]
         && pin_level_reg) |=> state_reg == RLS_RUN)
        else $error("WAIT not left at once.");
    a_wait_clock: assert property (@(posedge mclk) // [R15] [R17]
        disable iff (rst)
        (state_reg == RLS_WAIT) |-> (osc_enable && !core_run))
        else $error("WAIT stopped the clock or kept running.");
    a_stop_to_stab: assert property (@(posedge mclk) // [R20]
        disable iff (rst)
        (state_reg == RLS_STOP && irq.ext_irq && pin_level_reg)
        |=> state_reg == RLS_STAB)
        else $error("STOP exit skipped stabilisation.");
    a_stop_clock: assert property (@(posedge mclk) // [R19]
        disable iff (rst)
        (state_reg == RLS_STOP) |-> (!osc_enable && !core_run))
        else $error("STOP left the oscillator or core running.");
endmodule

// >>> bench/rls_far_side.sv
// Far-side model: external reset circuit, interrupt sources, vector ROM.
// Assumes the bench commands it from the mclk domain; the pin has a pull-up.
`timescale 1ns/100ps
module rls_far_side (
    input wire logic hold_low,
    input wire logic [2:0] irq_cmd,
    input wire logic pin_oe,
    output logic pin_level,
    output rls_pkg::rls_irq_t irq,
    input wire logic [11:0] rom_addr,
    output logic [7:0] rom_data
);
    import rls_pkg::*;
    // Open-drain pin: either party pulls it low, otherwise the pull-up wins.
    assign pin_level = !(hold_low || pin_oe);
    // Interrupt request levels as commanded by the bench.
    assign irq = irq_cmd;
    // Vector bytes at the two top words; other addresses show a pattern.
    always_comb begin
        if (rom_addr == RESET_VECTOR_LO) begin
            rom_data = 8'h34;
        end else if (rom_addr == RESET_VECTOR_HI) begin
            rom_data = 8'hA2;
        end else begin
            rom_data = rom_addr[7:0] ^ 8'hA5;
        end
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the sequencer: reset, registers, WAIT, STOP, dog.
// Assumes rls_far_side as pin, interrupt and ROM partner; short count S.
`timescale 1ns/100ps
module testbench;
    import rls_pkg::*;
    localparam int S = 16;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hold_low = 1'b1;
    logic [2:0] irq_cmd = 3'h0;
    logic wait_req = 1'b0;
    logic stop_req = 1'b0;
    logic ret_pulse = 1'b0;
    logic wdg_tick = 1'b0;
    logic wdg_refresh = 1'b0;
    rls_bus_t bus = '0;
    rls_irq_t irq;
    logic pin_level, pin_oe, core_run, io_reset, osc_enable, nmi_mode;
    logic service_pending, stack_clear, pc_load_en, pin_out;
    logic [7:0] rdata, rom_data, prescaler, tcount;
    logic [11:0] rom_addr, pc_load;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    // Clock of 50 MHz.
    always #10 mclk = ~mclk;
    rls_sequencer #(.STAB_COUNT(S)) dut (.mclk(mclk), .rst(rst),
        .reset_pin_in(pin_level), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe),
        .bus(bus), .rdata(rdata), .irq(irq), .wait_req(wait_req),
        .stop_req(stop_req), .return_from_handler_instruction(ret_pulse),
        .wdg_tick(wdg_tick), .wdg_refresh(wdg_refresh), .rom_data(rom_data),
        .rom_addr(rom_addr), .core_run(core_run), .io_reset(io_reset),
        .osc_enable(osc_enable), .nmi_mode(nmi_mode),
        .service_pending(service_pending), .stack_clear(stack_clear),
        .pc_load(pc_load), .pc_load_en(pc_load_en),
        .timer_prescaler(prescaler),
        .timer_count_register(tcount));
    rls_far_side far (.hold_low(hold_low), .irq_cmd(irq_cmd), .pin_oe(pin_oe),
        .pin_level(pin_level), .irq(irq), .rom_addr(rom_addr),
        .rom_data(rom_data));
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Waits a number of edges, then lets their updates land.
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // One-cycle register read; the data stand in the following cycle.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        chk("reg_read", rdata, exp);
    endtask
    // One-cycle pulse on wait, stop, return and tick (one-hot in that order).
    task automatic pulse(input logic [3:0] k);
        @(posedge mclk);
        {wait_req, stop_req, ret_pulse, wdg_tick} <= k;
        @(posedge mclk);
        {wait_req, stop_req, ret_pulse, wdg_tick} <= 4'h0;
    endtask
    // Bounded wait for core_run to reach v; n holds the edges taken.
    task automatic wait_run(input logic v);
        n = 0;
        while (core_run !== v) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 5000) begin
                fail_count++;
                wrap_up();
            end
        end
    endtask
    // Bounded wait for the pin pull (sel) or the I/O reset to reach v.
    task automatic poll(input bit sel, input logic v);
        for (n = 0; n < 12 && (sel ? pin_oe : io_reset) !== v; n++) begin
            cyc(1);
        end
    endtask
    // Sets all three interrupt levels at a clock edge.
    task automatic set_irq(input logic [2:0] v);
        @(posedge mclk);
        irq_cmd <= v;
    endtask
    // Main sequence.
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        cyc(20);
        chk("io_reset", {io_reset, core_run, stack_clear}, 3'b101);
        rchk(STATUS_OFS, 8'(RLS_RESET));
        @(posedge mclk);
        hold_low <= 1'b0;
        wait_run(1'b1);
        chk("release_len", n >= S && n <= S + 10, 1'b1);
        chk("pc_load", pc_load, 12'h234);
        chk("pc_load_en", pc_load_en, 1'b1);
        chk("nmi_mode", nmi_mode, 1'b1);
        chk("prescaler", prescaler, PRESCALER_RST);
        chk("timer_count", tcount, TIMER_COUNT_RST);
        rchk(WATCHDOG_COUNT_OFS, WATCHDOG_COUNT_RST);
        rchk(8'h55, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(DATA_WINDOW_SELECT_OFS + 8'(i), 8'h11 * 8'(i + 1));
        end
        wr(WATCHDOG_COUNT_OFS, 8'h5A);
        rchk(WATCHDOG_COUNT_OFS, 8'h5A);
        // Pin reset: selects survive, watchdog count is preset again.
        @(posedge mclk);
        hold_low <= 1'b1;
        wait_run(1'b0);
        cyc(5);
        chk("io_reset_pin", io_reset, 1'b1);
        @(posedge mclk);
        hold_low <= 1'b0;
        wait_run(1'b1);
        for (int i = 0; i < 3; i++) begin
            rchk(DATA_WINDOW_SELECT_OFS + 8'(i), 8'h11 * 8'(i + 1));
        end
        rchk(WATCHDOG_COUNT_OFS, WATCHDOG_COUNT_RST);
        // Return with a pending enabled timer request.
        wr(CONTROL_OFS, 8'h02);
        set_irq(3'b100);
        pulse(4'h2);
        n = 0;
        for (int i = 0; i < 6; i++) begin
            #1;
            if (service_pending === 1'b1) n++;
            @(posedge mclk);
        end
        chk("service_pending", n > 0, 1'b1);
        chk("nmi_mode_ret", nmi_mode, 1'b0);
        irq_cmd <= 3'b000;
        // WAIT left by the converter and the timer, with no delay.
        wr(CONTROL_OFS, 8'h0E);
        for (int i = 1; i < 3; i++) begin
            pulse(4'h8);
            rchk(STATUS_OFS, 8'(RLS_WAIT));
            chk("wait_osc", {core_run, osc_enable}, 2'b01);
            set_irq(3'(1 << i));
            wait_run(1'b1);
            chk("wait_exit", n <= 4, 1'b1);
            set_irq(3'b000);
        end
        // STOP left by an external request after the full count.
        pulse(4'h4);
        rchk(STATUS_OFS, 8'(RLS_STOP));
        chk("stop_osc", {core_run, osc_enable}, 2'b00);
        set_irq(3'b001);
        wait_run(1'b1);
        chk("stop_exit", n >= S && n <= S + 10, 1'b1);
        // Both sleep requests are refused while the request still pends.
        pulse(4'h8);
        pulse(4'h4);
        cyc(3);
        chk("refused", core_run, 1'b1);
        set_irq(3'b000);
        // With the watchdog on, STOP becomes WAIT.
        wr(CONTROL_OFS, 8'h0F);
        wr(WATCHDOG_COUNT_OFS, 8'h00);
        pulse(4'h4);
        rchk(STATUS_OFS, 8'(RLS_WAIT));
        // Watchdog end of count in WAIT pulls the pin and resets fully.
        pulse(4'h1);
        poll(1'b1, 1'b1);
        chk("pin_pull", {pin_oe, pin_out}, 2'b10);
        poll(1'b0, 1'b1);
        chk("wdg_io_reset", io_reset, 1'b1);
        poll(1'b1, 1'b0);
        chk("pin_free", pin_oe, 1'b0);
        wait_run(1'b1);
        chk("wdg_pc", {nmi_mode, pc_load}, 13'h1234);
        rchk(CONTROL_OFS, 8'h00);
        // Power-on pulse alone with the pin high.
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("por_hold", core_run, 1'b0);
        wait_run(1'b1);
        chk("por_len", n >= S && n <= S + 10, 1'b1);
        wrap_up();
    end
endmodule
